// *** design/mb_rtu_resp.sv ***
// slave frame checker and response builder for the serial field bus
`timescale 1ns/1ps
module mb_rtu_resp
   import mb_resp_pkg::*;
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // configuration
   input wire logic [7:0] i_node_addr,
   input wire logic [1:0] i_cfg_parity,
   // received characters from the serial receiver
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_data,
   input wire logic i_rx_parity,
   input wire logic i_rx_stop,
   input wire logic i_frame_end,
   // execution handshake with the application
   output logic o_exec_req,
   output logic [7:0] o_exec_func,
   output logic o_exec_bcast,
   output logic [8:0] o_exec_len,
   input wire logic i_exec_done,
   input wire logic i_exec_ok,
   input wire logic [7:0] i_exec_code,
   // stored query read port
   input wire logic [7:0] i_q_idx,
   output logic [7:0] o_q_data,
   // response payload pull
   output logic o_rsp_pop,
   input wire logic i_rsp_valid,
   input wire logic [7:0] i_rsp_data,
   input wire logic i_rsp_last,
   // bytes to the serial transmitter
   output logic o_tx_valid,
   output logic [7:0] o_tx_data,
   input wire logic i_tx_ready,
   // per-frame error pulses
   output logic o_err_framing,
   output logic o_err_parity,
   output logic o_err_crc,
   output logic o_err_length
);
   ////////////////////////////////////////////////////////////////////////
   // checksum units
   crc_if rxc (.clk(i_clk_sys), .resetn(i_resetn));  // query checksum
   crc_if txc (.clk(i_clk_sys), .resetn(i_resetn));  // reply checksum
   crc16_unit u_rx_crc (.p(rxc));
   crc16_unit u_tx_crc (.p(txc));

   ////////////////////////////////////////////////////////////////////////
   // state
   resp_state_t st_r, st_nxt;                  // sequencer
   logic [8:0] cnt_r, cnt_nxt;                 // bytes in this frame
   logic fe_r, fe_nxt, pe_r, pe_nxt;           // sticky char errors
   logic le_r, le_nxt;                         // sticky length error
   logic [15:0] hist1_r, hist1_nxt;            // crc before last byte
   logic [15:0] hist2_r, hist2_nxt;            // crc before last two
   logic [7:0] last1_r, last1_nxt;             // newest byte
   logic [7:0] last2_r, last2_nxt;             // byte before newest
   logic [7:0] addr_r, addr_nxt;               // query address byte
   logic [7:0] func_r, func_nxt;               // query function code
   logic bcast_r, bcast_nxt;                   // query was broadcast
   logic exc_r, exc_nxt;                       // replying with exception
   logic [7:0] code_r, code_nxt;               // exception reason
   logic pend_r, pend_nxt;                     // payload byte requested
   logic lastb_r, lastb_nxt;                   // body byte is the last
   logic tx_valid_r, tx_valid_nxt;
   logic [7:0] tx_data_r, tx_data_nxt;
   logic pop_r, pop_nxt;
   logic exec_r, exec_nxt;
   logic [8:0] len_r, len_nxt;
   logic efr_r, efr_nxt, epa_r, epa_nxt;       // error pulses
   logic ecr_r, ecr_nxt, ele_r, ele_nxt;
   logic [7:0] q_data_r;                       // stored query read data
   logic [7:0] mem [0:255];                    // query bytes

   ////////////////////////////////////////////////////////////////////////
   // helpers
   logic take;       // byte accepted into this frame
   logic par_bad;    // parity disagrees with setting
   logic hs;         // transmit handshake
   logic supported;  // function code known
   logic addr_hit;   // addressed to us or broadcast
   logic crc_bad;    // trailing checksum mismatch
   logic drop_addr;  // clean frame for another node

   assign take = (st_r == ST_RX) && i_rx_valid;
   assign hs = tx_valid_r && i_tx_ready;
   assign supported = (func_r == FC_RD_HOLD) || (func_r == FC_WR_ONE) ||
                      (func_r == FC_DIAG) || (func_r == FC_WR_MULTI);
   assign addr_hit = (addr_r == i_node_addr) || (addr_r == BCAST_ADDR);
   // checksum field is low byte then high byte
   assign crc_bad = ({last1_r, last2_r} != hist2_r) || (cnt_r < MIN_LEN);
   assign drop_addr = (st_r == ST_RX) && i_frame_end && !fe_r && !pe_r &&
                      !le_r && !crc_bad && !addr_hit;

   // parity: even wants an even count of ones over data and parity
   always_comb begin
      case (i_cfg_parity)
         PAR_EVEN: par_bad = ^{i_rx_data, i_rx_parity};
         PAR_ODD: par_bad = ~(^{i_rx_data, i_rx_parity});
         default: par_bad = 1'b0;
      endcase
   end

   // checksum unit hookup: bytes past the limit are not folded in
   assign rxc.clr = (st_r == ST_RX) && i_frame_end;
   assign rxc.en = take && (cnt_r < MAX_LEN);
   assign rxc.data = i_rx_data;
   assign txc.clr = (st_r == ST_RX) || (st_r == ST_EXEC);
   assign txc.en = hs && ((st_r == ST_TX_ADDR) || (st_r == ST_TX_FUNC) ||
                          (st_r == ST_TX_BODY));
   assign txc.data = tx_data_r;

   ////////////////////////////////////////////////////////////////////////
   // query store; one-cycle read latency on the application port
   always_ff @(posedge i_clk_sys) begin
      if (rxc.en) begin
         mem[cnt_r[7:0]] <= i_rx_data;
      end
      q_data_r <= mem[i_q_idx];
   end

   ////////////////////////////////////////////////////////////////////////
   // next-state logic for receive, decision and transmit
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      fe_nxt = fe_r;
      pe_nxt = pe_r;
      le_nxt = le_r;
      hist1_nxt = hist1_r;
      hist2_nxt = hist2_r;
      last1_nxt = last1_r;
      last2_nxt = last2_r;
      addr_nxt = addr_r;
      func_nxt = func_r;
      bcast_nxt = bcast_r;
      exc_nxt = exc_r;
      code_nxt = code_r;
      pend_nxt = pend_r;
      lastb_nxt = lastb_r;
      tx_valid_nxt = tx_valid_r;
      tx_data_nxt = tx_data_r;
      pop_nxt = 1'b0;
      exec_nxt = 1'b0;
      len_nxt = len_r;
      efr_nxt = 1'b0;
      epa_nxt = 1'b0;
      ecr_nxt = 1'b0;
      ele_nxt = 1'b0;
      case (st_r)
         ST_RX: begin
            if (i_frame_end) begin
               // the gap closes the frame; judge it now
               efr_nxt = fe_r;
               epa_nxt = pe_r;
               ele_nxt = le_r;
               ecr_nxt = crc_bad && !fe_r && !pe_r && !le_r;
               bcast_nxt = (addr_r == BCAST_ADDR);
               len_nxt = cnt_r;
               if (fe_r || pe_r || le_r || crc_bad || !addr_hit) begin
                  st_nxt = ST_RX;
               end else if (!supported) begin
                  // broadcasts are never answered, even in error
                  exc_nxt = 1'b1;
                  code_nxt = EXC_BAD_FUNC;
                  st_nxt = bcast_nxt ? ST_RX : ST_TX_ADDR;
               end else begin
                  exc_nxt = 1'b0;
                  exec_nxt = 1'b1;
                  st_nxt = ST_EXEC;
               end
               cnt_nxt = 9'h000;
               fe_nxt = 1'b0;
               pe_nxt = 1'b0;
               le_nxt = 1'b0;
               hist1_nxt = CRC_INIT;
               hist2_nxt = CRC_INIT;
            end else if (take) begin
               if (!i_rx_stop) begin
                  fe_nxt = 1'b1;
               end
               if (par_bad) begin
                  pe_nxt = 1'b1;
               end
               if (cnt_r == MAX_LEN) begin
                  le_nxt = 1'b1;
               end else begin
                  cnt_nxt = cnt_r + 9'h001;
                  hist1_nxt = rxc.crc;
                  hist2_nxt = hist1_r;
                  last1_nxt = i_rx_data;
                  last2_nxt = last1_r;
                  if (cnt_r == 9'h000) begin
                     addr_nxt = i_rx_data;
                  end
                  if (cnt_r == 9'h001) begin
                     func_nxt = i_rx_data;
                  end
               end
            end
         end
         ST_EXEC: begin
            if (i_exec_done) begin
               exc_nxt = !i_exec_ok;
               code_nxt = i_exec_code;
               st_nxt = bcast_r ? ST_RX : ST_TX_ADDR;
            end
         end
         ST_TX_ADDR: begin
            // reply opens with our own address
            if (!tx_valid_r) begin
               tx_valid_nxt = 1'b1;
               tx_data_nxt = addr_r;
            end else if (hs) begin
               tx_valid_nxt = 1'b0;
               st_nxt = ST_TX_FUNC;
            end
         end
         ST_TX_FUNC: begin
            if (!tx_valid_r) begin
               tx_valid_nxt = 1'b1;
               tx_data_nxt = exc_r ? func_r + EXC_OFFSET : func_r;
            end else if (hs) begin
               tx_valid_nxt = 1'b0;
               pend_nxt = 1'b0;
               st_nxt = ST_TX_BODY;
            end
         end
         ST_TX_BODY: begin
            if (!tx_valid_r) begin
               if (exc_r) begin
                  tx_valid_nxt = 1'b1;
                  tx_data_nxt = code_r;
                  lastb_nxt = 1'b1;
               end else if (!pend_r) begin
                  pop_nxt = 1'b1;
                  pend_nxt = 1'b1;
               end else if (i_rsp_valid) begin
                  tx_valid_nxt = 1'b1;
                  tx_data_nxt = i_rsp_data;
                  lastb_nxt = i_rsp_last;
                  pend_nxt = 1'b0;
               end
            end else if (hs) begin
               tx_valid_nxt = 1'b0;
               st_nxt = lastb_r ? ST_TX_CRCL : ST_TX_BODY;
            end
         end
         ST_TX_CRCL: begin
            if (!tx_valid_r) begin
               tx_valid_nxt = 1'b1;
               tx_data_nxt = txc.crc[7:0];
            end else if (hs) begin
               tx_valid_nxt = 1'b0;
               st_nxt = ST_TX_CRCH;
            end
         end
         ST_TX_CRCH: begin
            if (!tx_valid_r) begin
               tx_valid_nxt = 1'b1;
               tx_data_nxt = txc.crc[15:8];
            end else if (hs) begin
               tx_valid_nxt = 1'b0;
               st_nxt = ST_RX;
            end
         end
         default: begin
            st_nxt = ST_RX;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // registers only
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         st_r <= ST_RX;
         cnt_r <= 9'h000;
         fe_r <= 1'b0;
         pe_r <= 1'b0;
         le_r <= 1'b0;
         hist1_r <= CRC_INIT;
         hist2_r <= CRC_INIT;
         last1_r <= 8'h00;
         last2_r <= 8'h00;
         addr_r <= 8'h00;
         func_r <= 8'h00;
         bcast_r <= 1'b0;
         exc_r <= 1'b0;
         code_r <= 8'h00;
         pend_r <= 1'b0;
         lastb_r <= 1'b0;
         tx_valid_r <= 1'b0;
         tx_data_r <= 8'h00;
         pop_r <= 1'b0;
         exec_r <= 1'b0;
         len_r <= 9'h000;
         efr_r <= 1'b0;
         epa_r <= 1'b0;
         ecr_r <= 1'b0;
         ele_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         fe_r <= fe_nxt;
         pe_r <= pe_nxt;
         le_r <= le_nxt;
         hist1_r <= hist1_nxt;
         hist2_r <= hist2_nxt;
         last1_r <= last1_nxt;
         last2_r <= last2_nxt;
         addr_r <= addr_nxt;
         func_r <= func_nxt;
         bcast_r <= bcast_nxt;
         exc_r <= exc_nxt;
         code_r <= code_nxt;
         pend_r <= pend_nxt;
         lastb_r <= lastb_nxt;
         tx_valid_r <= tx_valid_nxt;
         tx_data_r <= tx_data_nxt;
         pop_r <= pop_nxt;
         exec_r <= exec_nxt;
         len_r <= len_nxt;
         efr_r <= efr_nxt;
         epa_r <= epa_nxt;
         ecr_r <= ecr_nxt;
         ele_r <= ele_nxt;
      end
   end

   // outputs straight from flops
   assign o_exec_req = exec_r;
   assign o_exec_func = func_r;
   assign o_exec_bcast = bcast_r;
   assign o_exec_len = len_r;
   assign o_q_data = q_data_r;
   assign o_rsp_pop = pop_r;
   assign o_tx_valid = tx_valid_r;
   assign o_tx_data = tx_data_r;
   assign o_err_framing = efr_r;
   assign o_err_parity = epa_r;
   assign o_err_crc = ecr_r;
   assign o_err_length = ele_r;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);

   sequence s_silent;
      (st_r == ST_RX) && !o_tx_valid;
   endsequence
   sequence s_func_sent;
      hs && (st_r == ST_TX_FUNC);
   endsequence

   property p_crc_start;
      (st_r == ST_TX_ADDR) && hs |-> txc.crc == 16'hFFFF;
   endproperty
   a_crc_start: assert property (p_crc_start)
      else $error("reply checksum did not start at all ones");
   property p_framing;
      o_err_framing |-> s_silent ##1 s_silent;
   endproperty
   a_framing: assert property (p_framing)
      else $error("reply after framing error");
   property p_parity;
      o_err_parity |-> s_silent ##1 s_silent;
   endproperty
   a_parity: assert property (p_parity)
      else $error("reply after parity error");
   property p_crc_err;
      o_err_crc |-> s_silent and !o_exec_req;
   endproperty
   a_crc_err: assert property (p_crc_err)
      else $error("query acted on despite checksum error");
   property p_length;
      o_err_length |-> s_silent and !o_exec_req;
   endproperty
   a_length: assert property (p_length)
      else $error("over-long frame acted on");
   property p_bcast;
      o_exec_req && o_exec_bcast |-> !o_tx_valid [*8];
   endproperty
   a_bcast: assert property (p_bcast)
      else $error("broadcast query answered");
   property p_foreign;
      drop_addr |=> s_silent ##1 (s_silent and !o_exec_req);
   endproperty
   a_foreign: assert property (p_foreign)
      else $error("foreign query acted on");
   property p_exc_func;
      s_func_sent and exc_r |-> o_tx_data == (func_r + 8'h80);
   endproperty
   a_exc_func: assert property (p_exc_func)
      else $error("exception function code lacks offset");
   property p_exc_len;
      hs && exc_r && (st_r == ST_TX_BODY) |=> st_r == ST_TX_CRCL;
   endproperty
   a_exc_len: assert property (p_exc_len)
      else $error("exception body is not one byte");
   property p_bad_func;
      (st_r == ST_RX) && (st_nxt == ST_TX_ADDR) |=>
         exc_r && code_r == 8'h01 && !o_exec_req;
   endproperty
   a_bad_func: assert property (p_bad_func)
      else $error("unsupported code not answered with reason 01h");
endmodule // mb_rtu_resp

// *** design/mb_resp_pkg.sv ***
// constants and types shared by the frame checker and response builder
package mb_resp_pkg;
   // checksum arithmetic
   localparam logic [15:0] CRC_INIT = 16'hFFFF;   // all ones at frame start
   localparam logic [15:0] CRC_POLY = 16'hA001;   // reflected polynomial
   // frame geometry
   localparam logic [8:0] MAX_LEN = 9'h100;       // longest legal frame
   localparam logic [8:0] MIN_LEN = 9'h004;       // addr, func, two checks
   localparam logic [7:0] BCAST_ADDR = 8'h00;     // address of every slave
   // exception encoding
   localparam logic [7:0] EXC_OFFSET = 8'h80;     // added to the func code
   localparam logic [7:0] EXC_BAD_FUNC = 8'h01;   // unsupported func code
   // supported function codes
   localparam logic [7:0] FC_RD_HOLD = 8'h03;
   localparam logic [7:0] FC_WR_ONE = 8'h06;
   localparam logic [7:0] FC_DIAG = 8'h08;
   localparam logic [7:0] FC_WR_MULTI = 8'h10;
   // parity setting encodings
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_ODD = 2'h2;
   // main sequencer states
   typedef enum logic [2:0] {
      ST_RX, ST_EXEC, ST_TX_ADDR, ST_TX_FUNC, ST_TX_BODY, ST_TX_CRCL,
      ST_TX_CRCH
   } resp_state_t;
endpackage

// *** design/crc_if.sv ***
// carrier between the sequencer and a checksum unit
`timescale 1ns/1ps
interface crc_if (
   input wire logic clk,
   input wire logic resetn
);
   logic clr;          // restart at the initial value
   logic en;           // fold one byte in
   logic [7:0] data;   // byte to fold
   logic [15:0] crc;   // running checksum
   modport unit (input clk, resetn, clr, en, data, output crc);
   modport user (output clr, en, data, input crc);
endinterface // crc_if

// *** design/crc16_unit.sv ***
// byte-wide running checksum register
`timescale 1ns/1ps
module crc16_unit
   import mb_resp_pkg::*;
(
   crc_if.unit p
);
   logic [15:0] crc_nxt;  // value after this cycle

   // one byte per cycle: xor low end, then eight conditional shifts
   always_comb begin
      crc_nxt = p.crc;
      if (p.clr) begin
         crc_nxt = CRC_INIT;
      end else if (p.en) begin
         crc_nxt = p.crc ^ {8'h00, p.data};
         for (int i = 0; i < 8; i++) begin
            if (crc_nxt[0]) begin
               crc_nxt = (crc_nxt >> 1) ^ CRC_POLY;
            end else begin
               crc_nxt = crc_nxt >> 1;
            end
         end
      end
   end

   // register only
   always_ff @(posedge p.clk) begin
      if (!p.resetn) begin
         p.crc <= CRC_INIT;
      end else begin
         p.crc <= crc_nxt;
      end
   end
endmodule // crc16_unit

// *** bench/mb_master_model.sv ***
// master-side model: sends query characters and accepts reply bytes
`timescale 1ns/1ps
module mb_master_model (
   // clock
   input wire logic i_clk,
   // characters towards the slave
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   output logic o_rx_parity,
   output logic o_rx_stop,
   output logic o_frame_end,
   // reply bytes from the slave
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   output logic o_tx_ready
);
   logic [7:0] got_q[$]; // reply bytes taken so far
   logic slow_r; // toggles so the slave sees a stalling receiver

   initial begin
      o_rx_valid = 1'b0;
      o_rx_data = 8'h00;
      o_rx_parity = 1'b0;
      o_rx_stop = 1'b1;
      o_frame_end = 1'b0;
      o_tx_ready = 1'b0;
      slow_r = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // checksum over a byte list, low end first
   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         for (int k = 0; k < 8; k++) begin
            c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
         end
      end
      return c;
   endfunction

   // bad: 0 clean, 1 stop bit low, 2 wrong parity, 3 wrong checksum
   task automatic send(input logic [7:0] b[$], input int bad);
      logic [15:0] c;
      c = crc16(b) ^ ((bad == 3) ? 16'h0001 : 16'h0000);
      b.push_back(c[7:0]);
      b.push_back(c[15:8]);
      foreach (b[i]) begin
         @(posedge i_clk);
         o_rx_valid <= 1'b1;
         o_rx_data <= b[i];
         // even parity, flipped on one byte when asked
         o_rx_parity <= (^b[i]) ^ (bad == 2 && i == 1);
         o_rx_stop <= !(bad == 1 && i == 2);
         @(posedge i_clk);
         o_rx_valid <= 1'b0;
         o_rx_data <= ~b[i]; // released line never shows the old byte
      end
      @(posedge i_clk);
      o_frame_end <= 1'b1;
      @(posedge i_clk);
      o_frame_end <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // reply acceptance, ready only every other cycle
   always @(posedge i_clk) begin
      if (i_tx_valid && o_tx_ready) begin
         got_q.push_back(i_tx_data);
      end
      slow_r <= ~slow_r;
      o_tx_ready <= slow_r;
   end
endmodule // mb_master_model

// *** bench/test_mb_rtu_resp.sv ***
// self-checking bench for the slave frame checker and response builder
`timescale 1ns/1ps
`define CHK(name, exp, got) begin checks++; if ((exp) !== (got)) begin \
   failures++; $display("CHECK FAILED %s expected %0h seen %0h", \
   name, exp, got); end end
module test_mb_rtu_resp
   import mb_resp_pkg::*;
;
   typedef struct {
      logic [7:0] adr, fc;   // query address and function
      logic ok;              // application verdict
      logic [7:0] code;      // exception reason from application
      logic ex, rep;         // execution and reply expected
      logic [7:0] rfc, body; // reply function and third byte
   } row_t;
   row_t rows[8] = '{
      '{8'h01, 8'h03, 1'b1, 8'h00, 1'b1, 1'b1, 8'h03, 8'hAA},
      '{8'h01, 8'h06, 1'b0, 8'h04, 1'b1, 1'b1, 8'h86, 8'h04},
      '{8'h01, 8'h08, 1'b1, 8'h00, 1'b1, 1'b1, 8'h08, 8'hAA},
      '{8'h01, 8'h10, 1'b0, 8'h03, 1'b1, 1'b1, 8'h90, 8'h03},
      '{8'h01, 8'h07, 1'b1, 8'h00, 1'b0, 1'b1, 8'h87, 8'h01},
      '{8'h00, 8'h06, 1'b1, 8'h00, 1'b1, 1'b0, 8'h00, 8'h00},
      '{8'h00, 8'h10, 1'b1, 8'h00, 1'b1, 1'b0, 8'h00, 8'h00},
      '{8'h05, 8'h03, 1'b1, 8'h00, 1'b0, 1'b0, 8'h00, 8'h00}
   };
   logic i_clk_sys = 1'b0;
   logic i_resetn = 1'b0;
   logic [1:0] cfg_par = PAR_EVEN; // parity setting under test
   logic rx_valid, rx_parity, rx_stop, frame_end, tx_ready;
   logic [7:0] rx_data, q_idx = 8'h00, q_data, exec_func, tx_data;
   logic exec_req, exec_bcast, rsp_pop, tx_valid;
   logic [8:0] exec_len;
   logic exec_done = 1'b0, exec_ok = 1'b1, rsp_valid = 1'b0;
   logic [7:0] exec_code = 8'h00;
   logic e_fr, e_par, e_crc, e_len;
   logic [3:0] errs; // framing, parity, checksum, length seen
   logic [7:0] seen_fc;
   logic seen_bc;
   logic [8:0] seen_len;
   int n_exec, checks = 0, failures = 0;

   always #25 i_clk_sys = ~i_clk_sys; // 20 MHz

   mb_rtu_resp mb_rtu_resp_i (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
      .i_node_addr(8'h01), .i_cfg_parity(cfg_par), .i_rx_valid(rx_valid),
      .i_rx_data(rx_data), .i_rx_parity(rx_parity), .i_rx_stop(rx_stop),
      .i_frame_end(frame_end), .o_exec_req(exec_req),
      .o_exec_func(exec_func), .o_exec_bcast(exec_bcast),
      .o_exec_len(exec_len), .i_exec_done(exec_done), .i_exec_ok(exec_ok),
      .i_exec_code(exec_code), .i_q_idx(q_idx), .o_q_data(q_data),
      .o_rsp_pop(rsp_pop), .i_rsp_valid(rsp_valid), .i_rsp_data(8'hAA),
      .i_rsp_last(1'b1), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
      .i_tx_ready(tx_ready), .o_err_framing(e_fr), .o_err_parity(e_par),
      .o_err_crc(e_crc), .o_err_length(e_len));

   mb_master_model mb_master_model_i (.i_clk(i_clk_sys),
      .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_parity(rx_parity),
      .o_rx_stop(rx_stop), .o_frame_end(frame_end), .i_tx_valid(tx_valid),
      .i_tx_data(tx_data), .o_tx_ready(tx_ready));

   ////////////////////////////////////////////////////////////////////////
   // application stand-in: answers each request the next cycle
   always @(posedge i_clk_sys) begin
      exec_done <= exec_req;
      rsp_valid <= rsp_pop;
      // write only on a pulse, so the clear in frame is never undone
      if (e_fr || e_par || e_crc || e_len) begin
         errs <= errs | {e_fr, e_par, e_crc, e_len};
      end
      if (exec_req) begin
         n_exec++;
         seen_fc = exec_func;
         seen_bc = exec_bcast;
         seen_len = exec_len;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // one query out, then wait for the expected reply bytes
   task automatic frame(input logic [7:0] adr, fc, input int nd, bad, want);
      logic [7:0] q[$];
      int k;
      q = '{adr, fc};
      for (k = 0; k < nd; k++) q.push_back(k[7:0]);
      errs = 4'h0;
      n_exec = 0;
      mb_master_model_i.got_q.delete();
      mb_master_model_i.send(q, bad);
      k = 0;
      while (k < 150 && mb_master_model_i.got_q.size() < want) begin
         @(posedge i_clk_sys);
         k++;
      end
      if (mb_master_model_i.got_q.size() < want) begin
         failures++;
         $display("CHECK FAILED reply wait expected %0d seen %0d", want,
            mb_master_model_i.got_q.size());
         summarize();
      end
      repeat (40) @(posedge i_clk_sys);
   endtask

   task automatic check_reply(input logic [7:0] adr, rfc, body);
      logic [7:0] e[$];
      logic [15:0] c;
      e = '{adr, rfc, body};
      c = mb_master_model_i.crc16(e);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
      `CHK("reply length", e.size(), mb_master_model_i.got_q.size())
      foreach (e[i])
         `CHK("reply byte", e[i], mb_master_model_i.got_q[i])
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge i_clk_sys);
      `CHK("tx valid in reset", 1'b0, tx_valid)
      i_resetn <= 1'b1;
      foreach (rows[r]) begin
         exec_ok <= rows[r].ok;
         exec_code <= rows[r].code;
         frame(rows[r].adr, rows[r].fc, 2, 0, rows[r].rep ? 5 : 0);
         `CHK("exec count", 32'(rows[r].ex), n_exec)
         if (rows[r].ex) begin
            `CHK("exec func", rows[r].fc, seen_fc)
            `CHK("exec bcast", rows[r].adr == 8'h00, seen_bc)
            `CHK("exec len", 9'h006, seen_len)
         end
         if (rows[r].rep) check_reply(rows[r].adr, rows[r].rfc, rows[r].body);
         else `CHK("reply count", 0, mb_master_model_i.got_q.size())
         `CHK("error flags", 4'h0, errs)
         if (r == 0) begin
            q_idx <= 8'h01;
            repeat (2) @(posedge i_clk_sys);
            `CHK("stored func", 8'h03, q_data)
         end
      end
      // framing, parity and checksum faults each drop the query
      for (int b = 1; b < 4; b++) begin
         frame(8'h01, 8'h03, 2, b, 0);
         `CHK("fault flags", 4'b1000 >> (b - 1), errs)
         `CHK("fault exec", 0, n_exec)
         `CHK("fault reply", 0, mb_master_model_i.got_q.size())
      end
      // odd setting flags every even-parity byte
      cfg_par <= PAR_ODD;
      frame(8'h01, 8'h03, 2, 0, 0);
      `CHK("odd parity flags", 4'b0100, errs)
      `CHK("odd parity exec", 0, n_exec)
      `CHK("odd parity reply", 0, mb_master_model_i.got_q.size())
      // no parity setting ignores a wrong parity bit
      cfg_par <= PAR_NONE;
      frame(8'h01, 8'h03, 2, 2, 5);
      `CHK("no parity flags", 4'h0, errs)
      `CHK("no parity exec", 1, n_exec)
      check_reply(8'h01, 8'h03, 8'hAA);
      cfg_par <= PAR_EVEN;
      // frame of 260 bytes is over the limit
      frame(8'h01, 8'h10, 256, 0, 0);
      `CHK("length flags", 4'b0001, errs)
      `CHK("length exec", 0, n_exec)
      `CHK("length reply", 0, mb_master_model_i.got_q.size())
      summarize();
   end
endmodule // test_mb_rtu_resp
